// [logic/wpt_defs.svh]
// Constants shared by both ends of the dual wiper two-wire link.
// Assumes a 25 MHz system clock and a 30 ns link sampling clock.
`ifndef WPT_DEFS_SVH
`define WPT_DEFS_SVH

// ----------------------------------------------------------------
// Control byte and command encodings
// ----------------------------------------------------------------
// Type code value is arbitrary
`define WPT_TYPE_CODE   4'h9
`define WPT_CMD_WR0     8'hA9
`define WPT_CMD_WR1     8'hAA
`define WPT_CMD_WRBOTH  8'hAF
`define WPT_WIPER_RST   8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WPT_CLK_NS      40
`define WPT_LINK_NS     30
`define WPT_SPIKE_NS    50
// Samples a level must persist to beat the longest spike
`define WPT_FILT_COUNT  ((`WPT_SPIKE_NS + `WPT_LINK_NS - 1) / `WPT_LINK_NS + 1)
`define WPT_T_LOW_NS    1300
// Quarter of an SCL period, rounded up
`define WPT_QUARTER     ((`WPT_T_LOW_NS / 2 + `WPT_CLK_NS - 1) / `WPT_CLK_NS)

`endif

// [logic/wpt_pkg.sv]
// Types shared by both ends of the dual wiper two-wire link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package wpt_pkg;

   typedef enum logic [2:0]
   {
      DEV_IDLE,
      DEV_RX,
      DEV_RXACK,
      DEV_TX,
      DEV_TXACK
   } wpt_dev_state_type;

   typedef enum logic [2:0]
   {
      MST_IDLE,
      MST_START,
      MST_BIT,
      MST_STOP,
      MST_DONE
   } wpt_mst_state_type;

endpackage

`default_nettype wire

// [logic/wpt_link_if.sv]
// Two-wire link between the bus master and the wiper device.
// Assumes both ends only pull SDA low; the wire idles high.
`default_nettype none

interface wpt_link_if;

   logic scl;
   logic mstSdaOut;
   logic mstSdaOe;
   logic devSdaOut;
   logic devSdaOe;
   wire  sda;

   // ----------------------------------------------------------------
   // Open-drain resolution
   // ----------------------------------------------------------------
   assign sda = ~((mstSdaOe & ~mstSdaOut) | (devSdaOe & ~devSdaOut));

   modport mst
   (
      output scl,
      output mstSdaOut,
      output mstSdaOe,
      input  sda
   );

   modport dev
   (
      input  scl,
      output devSdaOut,
      output devSdaOe,
      input  sda
   );

endinterface

`default_nettype wire

// [logic/wpt_master.sv]
// Two-wire bus master: frames reads and writes of the wiper device.
// Assumes a 25 MHz clk; SCL is divided from it and driven out.
`default_nettype none
`include "wpt_defs.svh"

module wpt_master
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Link
   wpt_link_if.mst         link,
   // Request
   input  wire logic       cmdValid,
   output logic            cmdReady,
   input  wire logic       cmdRead,
   input  wire logic [2:0] cmdSelect,
   input  wire logic [7:0] cmdCode,
   input  wire logic [1:0] cmdCount,
   input  wire logic [7:0] cmdData0,
   input  wire logic [7:0] cmdData1,
   // Answer
   output logic            rspValid,
   output logic            rspAcked,
   output logic [7:0]      rspData0,
   output logic [7:0]      rspData1
);

   wpt_pkg::wpt_mst_state_type state_q;
   logic [4:0] qCnt_q;
   logic [1:0] phase_q;
   logic [3:0] bitCnt_q;
   logic [2:0] byteIdx_q;
   logic [2:0] lastIdx_q;
   logic [7:0] sr_q;
   logic       read_q;
   logic       nak_q;
   logic       sclOut_q;
   logic       sdaLow_q;
   logic       sdaM1_q;
   logic       sdaM2_q;
   logic [7:0] code_q;
   logic [7:0] d0_q;
   logic [7:0] d1_q;
   logic       rspValid_q;
   logic [7:0] rx0_q;
   logic [7:0] rx1_q;

   wire        tick;
   wire        txing;
   wire        ackSlot;
   wire        lastByte;
   wire [7:0]  ctrlByte;
   wire [7:0]  nextTx;
   wire        sdaBit;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign tick     = qCnt_q == 5'(`WPT_QUARTER - 1);
   assign txing    = ~read_q | (byteIdx_q == 3'h0);
   assign ackSlot  = bitCnt_q == 4'h8;
   assign lastByte = byteIdx_q == lastIdx_q;
   assign ctrlByte = {`WPT_TYPE_CODE, cmdSelect, cmdRead};
   assign nextTx   = (byteIdx_q == 3'h0) ? code_q :
                     (byteIdx_q == 3'h1) ? d0_q : d1_q;
   // Master acks a read byte unless it is the last wanted
   assign sdaBit   = ackSlot ? (~txing & ~lastByte)
                             : (txing & ~sr_q[7]);
   assign cmdReady = state_q == wpt_pkg::MST_IDLE;

   assign link.scl       = sclOut_q;
   assign link.mstSdaOut = 1'b0;
   assign link.mstSdaOe  = sdaLow_q;
   assign rspValid       = rspValid_q;
   assign rspData0       = rx0_q;
   assign rspData1       = rx1_q;
   assign rspAcked       = ~nak_q;

   // ----------------------------------------------------------------
   // SDA synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      sdaM1_q <= link.sda;
      sdaM2_q <= sdaM1_q;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || state_q == wpt_pkg::MST_IDLE || tick)
         qCnt_q <= 5'h00;
      else
         qCnt_q <= qCnt_q + 5'h01;
   end

   // ----------------------------------------------------------------
   // Framing
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      rspValid_q <= 1'b0;
      if (!rst_b)
      begin
         state_q   <= wpt_pkg::MST_IDLE;
         phase_q   <= 2'h0;
         bitCnt_q  <= 4'h0;
         byteIdx_q <= 3'h0;
         lastIdx_q <= 3'h0;
         sr_q      <= 8'h00;
         read_q    <= 1'b0;
         nak_q     <= 1'b0;
         sclOut_q  <= 1'b1;
         sdaLow_q  <= 1'b0;
         code_q    <= 8'h00;
         d0_q      <= 8'h00;
         d1_q      <= 8'h00;
         rx0_q     <= 8'h00;
         rx1_q     <= 8'h00;
      end
      else
      begin
         case (state_q)
            wpt_pkg::MST_IDLE:
               if (cmdValid)
               begin
                  sr_q      <= ctrlByte;
                  read_q    <= cmdRead;
                  code_q    <= cmdCode;
                  d0_q      <= cmdData0;
                  d1_q      <= cmdData1;
                  lastIdx_q <= cmdRead ? {1'b0, cmdCount}
                                       : {1'b0, cmdCount} + 3'h1;
                  byteIdx_q <= 3'h0;
                  bitCnt_q  <= 4'h0;
                  nak_q     <= 1'b0;
                  phase_q   <= 2'h0;
                  state_q   <= wpt_pkg::MST_START;
               end
            wpt_pkg::MST_START:
               if (tick)
               begin
                  phase_q <= phase_q + 2'h1;
                  if (phase_q == 2'h0)
                     sdaLow_q <= 1'b1;
                  else
                  begin
                     sclOut_q <= 1'b0;
                     phase_q  <= 2'h0;
                     state_q  <= wpt_pkg::MST_BIT;
                  end
               end
            wpt_pkg::MST_BIT:
               if (tick)
               begin
                  phase_q <= phase_q + 2'h1;
                  case (phase_q)
                     2'h0: sdaLow_q <= sdaBit;
                     2'h1: sclOut_q <= 1'b1;
                     2'h2:
                        if (!ackSlot)
                           sr_q <= {sr_q[6:0], sdaM2_q};
                        else if (txing)
                           nak_q <= sdaM2_q;
                        else if (byteIdx_q == 3'h1)
                           rx0_q <= sr_q;
                        else
                           rx1_q <= sr_q;
                     default:
                     begin
                        sclOut_q <= 1'b0;
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (ackSlot)
                        begin
                           bitCnt_q  <= 4'h0;
                           byteIdx_q <= byteIdx_q + 3'h1;
                           sr_q      <= nextTx;
                           if (nak_q || lastByte)
                              state_q <= wpt_pkg::MST_STOP;
                        end
                     end
                  endcase
               end
            wpt_pkg::MST_STOP:
               if (tick)
               begin
                  phase_q <= phase_q + 2'h1;
                  case (phase_q)
                     2'h0: sdaLow_q <= 1'b1;
                     2'h1: sclOut_q <= 1'b1;
                     2'h2: sdaLow_q <= 1'b0;
                     default: state_q <= wpt_pkg::MST_DONE;
                  endcase
               end
            wpt_pkg::MST_DONE:
            begin
               rspValid_q <= 1'b1;
               state_q    <= wpt_pkg::MST_IDLE;
            end
            default: state_q <= wpt_pkg::MST_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// [logic/wpt_device.sv]
// Wiper device end: two-wire slave holding two 8-bit wiper positions.
// Assumes linkClk oversamples SCL/SDA; wiper outputs live on clk.
`default_nettype none
`include "wpt_defs.svh"

module wpt_device
(
   // System side
   input  wire logic       clk,
   input  wire logic       rst_b,
   output logic [7:0]      wiper0Pos,
   output logic [7:0]      wiper1Pos,
   output logic            wiperUpdated,
   // Link side
   input  wire logic       linkClk,
   input  wire logic       selectBit2,
   input  wire logic       selectBit1,
   input  wire logic       selectBit0,
   wpt_link_if.dev         link
);

   wpt_pkg::wpt_dev_state_type st_q;
   logic       rstL1_q;
   logic       lnkRst_b;
   logic [2:0] sel1_q;
   logic [2:0] sel2_q;
   logic       sclP_q;
   logic       sdaP_q;
   logic [3:0] bitCnt_q;
   logic [1:0] byteNo_q;
   logic [7:0] sr_q;
   logic       rdMode_q;
   logic [7:0] cmd_q;
   logic [7:0] w0_q;
   logic [7:0] w1_q;
   logic       updTgl_q;
   logic       drvLow_q;
   logic       txSel_q;
   logic       tgl1_q;
   logic       tgl2_q;
   logic       tgl3_q;
   logic [7:0] wiper0_q;
   logic [7:0] wiper1_q;
   logic       upd_q;

   wire [1:0]  rawPin;
   wire [1:0]  linesF;
   wire        sclF;
   wire        sdaF;
   wire        sclRise;
   wire        sclFall;
   wire        startCond;
   wire        stopCond;
   wire        byteDone;
   wire        addrMatch;
   wire        dataDone;
   wire        isWr0;
   wire        isWr1;
   wire        isBoth;
   wire        loadW0;
   wire        loadW1;
   wire [7:0]  nextTx;

   // ----------------------------------------------------------------
   // Link reset and pin conditioning
   // ----------------------------------------------------------------
   always_ff @(posedge linkClk)
   begin
      rstL1_q  <= rst_b;
      lnkRst_b <= rstL1_q;
      sel1_q   <= {selectBit2, selectBit1, selectBit0};
      sel2_q   <= sel1_q;
   end

   assign rawPin = {link.sda, link.scl};

   // Level must hold past a spike before it is believed
   for (genvar i = 0; i < 2; i++)
   begin : g_filt
      logic       s1_q;
      logic       s2_q;
      logic       flt_q;
      logic [1:0] cnt_q;
      always_ff @(posedge linkClk)
      begin
         s1_q <= rawPin[i];
         s2_q <= s1_q;
         if (!lnkRst_b || s2_q == flt_q)
            cnt_q <= 2'h0;
         else if (cnt_q == 2'(`WPT_FILT_COUNT - 1))
            cnt_q <= 2'h0;
         else
            cnt_q <= cnt_q + 2'h1;
         if (!lnkRst_b)
            flt_q <= 1'b1;
         else if (s2_q != flt_q && cnt_q == 2'(`WPT_FILT_COUNT - 1))
            flt_q <= s2_q;
      end
      assign linesF[i] = flt_q;
   end

   // ----------------------------------------------------------------
   // Bus conditions and decode
   // ----------------------------------------------------------------
   assign sclF      = linesF[0];
   assign sdaF      = linesF[1];
   assign sclRise   = sclF & ~sclP_q;
   assign sclFall   = ~sclF & sclP_q;
   assign startCond = sclF & sclP_q & sdaP_q & ~sdaF;
   assign stopCond  = sclF & sclP_q & ~sdaP_q & sdaF;
   assign byteDone  = (st_q == wpt_pkg::DEV_RX) & sclFall
                      & (bitCnt_q == 4'h8);
   assign addrMatch = (sr_q[7:4] == `WPT_TYPE_CODE)
                      & (sr_q[3:1] == sel2_q);
   assign dataDone  = byteDone & ~rdMode_q & byteNo_q[1];
   assign isWr0     = cmd_q == `WPT_CMD_WR0;
   assign isWr1     = cmd_q == `WPT_CMD_WR1;
   assign isBoth    = cmd_q == `WPT_CMD_WRBOTH;
   // Other command values load nothing
   assign loadW0    = dataDone & (byteNo_q == 2'h2)
                      & (isWr0 | isBoth);
   assign loadW1    = dataDone & (((byteNo_q == 2'h2)
                      & (isWr1 | isBoth))
                      | ((byteNo_q == 2'h3) & isWr0));
   assign nextTx    = txSel_q ? w1_q : w0_q;

   assign link.devSdaOut = 1'b0;
   assign link.devSdaOe  = drvLow_q;

   // ----------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------
   always_ff @(posedge linkClk)
   begin
      sclP_q <= sclF;
      sdaP_q <= sdaF;
      if (!lnkRst_b)
      begin
         st_q     <= wpt_pkg::DEV_IDLE;
         bitCnt_q <= 4'h0;
         byteNo_q <= 2'h0;
         sr_q     <= 8'h00;
         rdMode_q <= 1'b0;
         cmd_q    <= 8'h00;
         drvLow_q <= 1'b0;
         txSel_q  <= 1'b0;
      end
      else if (startCond)
      begin
         st_q     <= wpt_pkg::DEV_RX;
         bitCnt_q <= 4'h0;
         byteNo_q <= 2'h0;
         drvLow_q <= 1'b0;
      end
      else if (stopCond)
      begin
         st_q     <= wpt_pkg::DEV_IDLE;
         drvLow_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            wpt_pkg::DEV_IDLE: drvLow_q <= 1'b0;
            wpt_pkg::DEV_RX:
            begin
               if (sclRise)
               begin
                  sr_q     <= {sr_q[6:0], sdaF};
                  bitCnt_q <= bitCnt_q + 4'h1;
               end
               if (byteDone)
               begin
                  if (byteNo_q == 2'h0 && !addrMatch)
                     st_q <= wpt_pkg::DEV_IDLE;
                  else
                  begin
                     drvLow_q <= 1'b1;
                     st_q     <= wpt_pkg::DEV_RXACK;
                     if (byteNo_q != 2'h3)
                        byteNo_q <= byteNo_q + 2'h1;
                     if (byteNo_q == 2'h0)
                        rdMode_q <= sr_q[0];
                     if (byteNo_q == 2'h1)
                        cmd_q <= sr_q;
                  end
               end
            end
            wpt_pkg::DEV_RXACK:
               if (sclFall)
               begin
                  bitCnt_q <= 4'h0;
                  if (rdMode_q)
                  begin
                     sr_q     <= w0_q;
                     drvLow_q <= ~w0_q[7];
                     txSel_q  <= 1'b1;
                     st_q     <= wpt_pkg::DEV_TX;
                  end
                  else
                  begin
                     drvLow_q <= 1'b0;
                     st_q     <= wpt_pkg::DEV_RX;
                  end
               end
            wpt_pkg::DEV_TX:
            begin
               if (sclRise)
                  bitCnt_q <= bitCnt_q + 4'h1;
               if (sclFall && bitCnt_q == 4'h8)
               begin
                  drvLow_q <= 1'b0;
                  st_q     <= wpt_pkg::DEV_TXACK;
               end
               else if (sclFall)
               begin
                  sr_q     <= {sr_q[6:0], 1'b0};
                  drvLow_q <= ~sr_q[6];
               end
            end
            wpt_pkg::DEV_TXACK:
               if (sclRise && sdaF)
                  st_q <= wpt_pkg::DEV_IDLE;
               else if (sclFall)
               begin
                  // Keeps alternating if the master acks past wiper-1
                  sr_q     <= nextTx;
                  drvLow_q <= ~nextTx[7];
                  txSel_q  <= ~txSel_q;
                  bitCnt_q <= 4'h0;
                  st_q     <= wpt_pkg::DEV_TX;
               end
            default: st_q <= wpt_pkg::DEV_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Wiper registers
   // ----------------------------------------------------------------
   always_ff @(posedge linkClk)
   begin
      if (!lnkRst_b)
      begin
         w0_q     <= `WPT_WIPER_RST;
         w1_q     <= `WPT_WIPER_RST;
         updTgl_q <= 1'b0;
      end
      else
      begin
         if (loadW0)
            w0_q <= sr_q;
         if (loadW1)
            w1_q <= sr_q;
         if (loadW0 || loadW1)
            updTgl_q <= ~updTgl_q;
      end
   end

   // ----------------------------------------------------------------
   // Crossing to clk
   // ----------------------------------------------------------------
   // Wiper words hold still for a whole byte time after the toggle
   always_ff @(posedge clk)
   begin
      tgl1_q <= updTgl_q;
      tgl2_q <= tgl1_q;
      if (!rst_b)
      begin
         tgl3_q   <= 1'b0;
         wiper0_q <= `WPT_WIPER_RST;
         wiper1_q <= `WPT_WIPER_RST;
         upd_q    <= 1'b0;
      end
      else
      begin
         tgl3_q <= tgl2_q;
         upd_q  <= tgl2_q ^ tgl3_q;
         if (tgl2_q ^ tgl3_q)
         begin
            wiper0_q <= w0_q;
            wiper1_q <= w1_q;
         end
      end
   end

   assign wiper0Pos    = wiper0_q;
   assign wiper1Pos    = wiper1_q;
   assign wiperUpdated = upd_q;

endmodule

`default_nettype wire

// [test/wpt_link_properties.sv]
// Checker for the two-wire link joining master and wiper device.
// Assumes linkClk oversamples the link and the straps stay steady.
`default_nettype none
`include "wpt_defs.svh"

module wpt_link_properties
(
   // Clock and reset
   input wire logic linkClk,
   input wire logic rst_b,
   // Link
   input wire logic scl,
   input wire logic devSdaOut,
   input wire logic devSdaOe,
   input wire logic sda,
   // Straps
   input wire logic selectBit2,
   input wire logic selectBit1,
   input wire logic selectBit0
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------
   logic       sclQ;
   logic       sdaQ;
   logic [3:0] bitCntQ;
   logic [7:0] shiftQ;
   logic       firstQ;
   logic       dirQ;
   logic       matchQ;
   logic       silentQ;
   logic       rstL1_q;
   logic       lnkRst_b;

   wire sclRise   = scl & ~sclQ;
   wire startSeen = scl & sclQ & sdaQ & ~sda;
   wire stopSeen  = scl & sclQ & ~sdaQ & sda;
   wire ackSlot   = sclRise & (bitCntQ == 4'h8);
   wire ctlMatch  = (shiftQ[7:4] == `WPT_TYPE_CODE) &
                    (shiftQ[3:1] == {selectBit2, selectBit1, selectBit0});

   always_ff @(posedge linkClk)
   begin
      sclQ <= rst_b ? scl : 1'b1;
      sdaQ <= rst_b ? sda : 1'b1;
   end

   // Reset retimed as in the device; its link side lags the release
   always_ff @(posedge linkClk)
   begin
      rstL1_q  <= rst_b;
      lnkRst_b <= rstL1_q;
   end

   // Stop clock edge bumps the count too; harmless, start clears it
   always_ff @(posedge linkClk)
      if (!rst_b || startSeen)
      begin
         bitCntQ <= 4'h0;
         firstQ  <= rst_b;
         silentQ <= 1'b0;
      end
      else if (sclRise)
      begin
         bitCntQ <= ackSlot ? 4'h0 : bitCntQ + 4'h1;
         shiftQ  <= ackSlot ? shiftQ : {shiftQ[6:0], sda};
         firstQ  <= ackSlot ? 1'b0 : firstQ;
         dirQ    <= (ackSlot & firstQ) ? shiftQ[0] : dirQ;
         matchQ  <= (ackSlot & firstQ) ? ctlMatch : matchQ;
         silentQ <= (ackSlot & firstQ) ? ~ctlMatch : silentQ;
      end

   default clocking cb @(posedge linkClk);
   endclocking
   default disable iff (!lnkRst_b);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_ack_match;
      ackSlot && firstQ |-> sda == !ctlMatch;
   endproperty
   a_ack_match: assert property (p_ack_match)
      else $error("control byte ack wrong");
   property p_silent;
      silentQ |-> !devSdaOe;
   endproperty
   a_silent: assert property (p_silent)
      else $error("device drives after mismatch");
   property p_wr_ack;
      ackSlot && !firstQ && !dirQ && matchQ |-> !sda;
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("written byte not acked");
   property p_rd_release;
      ackSlot && !firstQ && dirQ |-> !devSdaOe;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("device drives master ack slot");
   property p_wr_quiet;
      sclRise && !firstQ && !dirQ && bitCntQ != 4'h8 |-> !devSdaOe;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet)
      else $error("device drives data in a write");
   property p_dev_stable;
      scl && sclQ |-> $stable(devSdaOe);
   endproperty
   a_dev_stable: assert property (p_dev_stable)
      else $error("device moves SDA with SCL high");
   property p_sda_hold;
      sclRise && !startSeen |-> $stable(sda) [*8];
   endproperty
   a_sda_hold: assert property (p_sda_hold)
      else $error("SDA moves early in clock high");
   property p_stop_free;
      stopSeen |-> !devSdaOe ##1 !devSdaOe;
   endproperty
   a_stop_free: assert property (p_stop_free)
      else $error("device holds SDA at stop");
   property p_open_drain;
      devSdaOe |-> devSdaOut == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("device drives SDA high");
   property p_ctl_quiet;
      sclRise && firstQ && bitCntQ != 4'h8 |-> !devSdaOe;
   endproperty
   a_ctl_quiet: assert property (p_ctl_quiet)
      else $error("device drives during control byte");

endmodule

`default_nettype wire

// [test/dual_wiper_two_wire_slave_tb.sv]
// Bench: master and wiper device joined by the link, self-checking.
// Assumes both design ends, the link and the checker compile first.
`default_nettype none
`include "wpt_defs.svh"

module dual_wiper_two_wire_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic       acked;
      logic [1:0] nRd;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [1:0] upd;
   } wpt_note_type;

   logic         clk;
   logic         linkClk;
   logic         rst_b;
   logic         cmdValid;
   logic         cmdReady;
   logic         cmdRead;
   logic [2:0]   cmdSelect;
   logic [7:0]   cmdCode;
   logic [1:0]   cmdCount;
   logic [7:0]   cmdData0;
   logic [7:0]   cmdData1;
   logic         rspValid;
   logic         rspAcked;
   logic [7:0]   rspData0;
   logic [7:0]   rspData1;
   logic [7:0]   wiper0Pos;
   logic [7:0]   wiper1Pos;
   logic         wiperUpdated;
   logic [2:0]   strap;
   logic [7:0]   expW0;
   logic [7:0]   expW1;
   logic [7:0]   codes [4];
   wpt_note_type note;
   wpt_note_type q [$];
   int           seed = 61687;
   int           miscompares = 0;
   int           checkCount = 0;
   int           cycles = 0;
   int           updSeen = 0;

   wpt_link_if link ();

   wpt_master wpt_master_i
   (
      .clk      (clk),
      .rst_b    (rst_b),
      .link     (link),
      .cmdValid (cmdValid),
      .cmdReady (cmdReady),
      .cmdRead  (cmdRead),
      .cmdSelect(cmdSelect),
      .cmdCode  (cmdCode),
      .cmdCount (cmdCount),
      .cmdData0 (cmdData0),
      .cmdData1 (cmdData1),
      .rspValid (rspValid),
      .rspAcked (rspAcked),
      .rspData0 (rspData0),
      .rspData1 (rspData1)
   );

   wpt_device wpt_device_i
   (
      .clk         (clk),
      .rst_b       (rst_b),
      .wiper0Pos   (wiper0Pos),
      .wiper1Pos   (wiper1Pos),
      .wiperUpdated(wiperUpdated),
      .linkClk     (linkClk),
      .selectBit2  (strap[2]),
      .selectBit1  (strap[1]),
      .selectBit0  (strap[0]),
      .link        (link)
   );

   wpt_link_properties wpt_link_properties_i
   (
      .linkClk   (linkClk),
      .rst_b     (rst_b),
      .scl       (link.scl),
      .devSdaOut (link.devSdaOut),
      .devSdaOe  (link.devSdaOe),
      .sda       (link.sda),
      .selectBit2(strap[2]),
      .selectBit1(strap[1]),
      .selectBit0(strap[0])
   );

   // ----------------------------------------------------------------
   // Clocks
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Odd offset keeps the two clocks out of step
   initial
   begin
      linkClk = 1'b0;
      #7;
      forever #15 linkClk = ~linkClk;
   end

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      checkCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task testDone;
      if (miscompares == 0 && checkCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Wipers are settled long before the stop ends the frame
   always @(posedge clk)
   begin
      cycles++;
      if (wiperUpdated === 1'b1)
         updSeen++;
      if (rspValid === 1'b1 && q.size() != 0)
      begin
         note = q.pop_front();
         chk8("acked", {7'h00, note.acked}, {7'h00, rspAcked});
         if (note.nRd != 2'h0)
            chk8("read byte 0", note.d0, rspData0);
         if (note.nRd == 2'h2)
            chk8("read byte 1", note.d1, rspData1);
         chk8("wiper 0", note.d0, wiper0Pos);
         chk8("wiper 1", note.d1, wiper1Pos);
         chk8("updates", {6'h00, note.upd}, updSeen[7:0]);
         updSeen = 0;
      end
      if (cycles > 60000)
      begin
         miscompares++;
         testDone();
      end
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   task automatic xfer(input logic rd, input logic [2:0] sel,
                       input logic [7:0] code, input logic [1:0] cnt,
                       input logic [7:0] a, input logic [7:0] b);
      wpt_note_type n;
      logic         wr;
      wr = (sel == strap) && !rd;
      if (wr && code == `WPT_CMD_WR0 && cnt == 2'h2)
         expW1 = b;
      if (wr && (code == `WPT_CMD_WR1 || code == `WPT_CMD_WRBOTH))
         expW1 = a;
      if (wr && (code == `WPT_CMD_WR0 || code == `WPT_CMD_WRBOTH))
         expW0 = a;
      n.acked = (sel == strap);
      n.nRd = (rd && n.acked) ? cnt : 2'h0;
      n.d0 = expW0;
      n.d1 = expW1;
      n.upd = !wr ? 2'h0 : (code == `WPT_CMD_WR0) ? cnt :
              (code == `WPT_CMD_WR1 || code == `WPT_CMD_WRBOTH) ? 2'h1 : 2'h0;
      q.push_back(n);
      cmdRead = rd;
      cmdSelect = sel;
      cmdCode = code;
      cmdCount = cnt;
      cmdData0 = a;
      cmdData1 = b;
      cmdValid = 1'b1;
      @(posedge clk);
      while (cmdReady !== 1'b1)
         @(posedge clk);
      #1 cmdValid = 1'b0;
      while (q.size() != 0)
         @(posedge clk);
      #1;
   endtask

   initial
   begin
      rst_b = 1'b0;
      cmdValid = 1'b0;
      cmdRead = 1'b0;
      cmdSelect = 3'h0;
      cmdCode = 8'h00;
      cmdCount = 2'h0;
      cmdData0 = 8'h00;
      cmdData1 = 8'h00;
      strap = 3'($random(seed));
      expW0 = `WPT_WIPER_RST;
      expW1 = `WPT_WIPER_RST;
      codes[0] = `WPT_CMD_WR0;
      codes[1] = `WPT_CMD_WR1;
      codes[2] = `WPT_CMD_WRBOTH;
      codes[3] = 8'($random(seed)) & 8'hF0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      // Let the device input filters settle high
      repeat (10) @(posedge clk);
      #1;
      xfer(1'b1, strap, 8'h00, 2'h2, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++)
         xfer(1'b0, strap, codes[i % 4], 2'(1 + i / 4),
              8'($random(seed)), 8'($random(seed)));
      xfer(1'b1, strap, 8'h00, 2'h1, 8'h00, 8'h00);
      for (int i = 0; i < 3; i++)
         xfer(i % 2 == 0, strap ^ (3'h1 << i), `WPT_CMD_WRBOTH, 2'h1,
              8'($random(seed)), 8'h00);
      xfer(1'b1, strap, 8'h00, 2'h2, 8'h00, 8'h00);
      testDone();
   end

endmodule

`default_nettype wire
